// ### hw/cidm_pkg.sv
// Package with constants and types for the identifier field mapping block.
package cidm_pkg;

  // Register indexes on the plain register port.
  localparam logic [2:0] CIDM_OFS_TX_B0 = 3'h0; // Transmit byte 0.
  localparam logic [2:0] CIDM_OFS_TX_B1 = 3'h1; // Transmit byte 1.
  localparam logic [2:0] CIDM_OFS_TX_B2 = 3'h2; // Transmit byte 2.
  localparam logic [2:0] CIDM_OFS_TX_B3 = 3'h3; // Transmit byte 3.
  localparam logic [2:0] CIDM_OFS_RX_B0 = 3'h4; // Receive byte 0.
  localparam logic [2:0] CIDM_OFS_RX_B1 = 3'h5; // Receive byte 1.
  localparam logic [2:0] CIDM_OFS_RX_B2 = 3'h6; // Receive byte 2.
  localparam logic [2:0] CIDM_OFS_RX_B3 = 3'h7; // Receive byte 3.

  // Field positions inside byte 1 and byte 3.
  localparam int CIDM_B1_SRR = 4; // Substitute remote request, extended.
  localparam int CIDM_B1_FMT = 3; // Format flag, both layouts.
  localparam int CIDM_B1_RTR_STD = 4; // Remote request, standard layout.
  localparam int CIDM_B3_RTR_EXT = 0; // Remote request, extended layout.

  // Entry lengths in bits.
  localparam logic [5:0] CIDM_EXT_BITS = 6'h20; // Extended entry length.
  localparam logic [5:0] CIDM_STD_BITS = 6'h0d; // Standard entry length.

  // Values after reset.
  localparam logic [7:0] CIDM_BYTE_RST = 8'h00; // Identifier byte reset.
  localparam logic [5:0] CIDM_CNT_RST = 6'h00; // Shift counter reset.

  // Format flag encodings.
  localparam logic CIDM_FMT_STD = 1'b0; // Standard 11-bit format.
  localparam logic CIDM_FMT_EXT = 1'b1; // Extended 29-bit format.

  // Unpacked identifier fields of one frame.
  typedef struct packed {
    logic [28:0] ident; // Identifier, right aligned for standard.
    logic srr; // Substitute remote request level.
    logic fmt; // Format flag.
    logic rtr; // Remote request flag.
  } cidm_fields_t;

  // Register port request group.
  typedef struct packed {
    logic [2:0] addr; // Register index.
    logic [7:0] wdata; // Write data.
    logic wr; // Write strobe.
    logic rd; // Read strobe.
  } cidm_req_t;

  // Shifter states.
  typedef enum logic [1:0] {
    CIDM_IDLE = 2'b01, // Waiting for a send request.
    CIDM_SEND = 2'b10 // Shifting identifier bits out.
  } cidm_state_t;

endpackage

// ### hw/cidm_shift.sv
// Serialiser that sends a packed identifier entry most significant first.
`timescale 1ns/1ps
module cidm_shift (
  input wire logic SYS_CLK, // Bus clock.
  input wire logic SRST, // Synchronous reset, active high.
  input wire logic start, // One-cycle request to send an entry.
  input wire logic [31:0] entry, // Entry, left aligned.
  input wire logic [5:0] nbits, // Number of bits to send.
  output logic bit_out, // Current serial bit.
  output logic bit_valid, // High while a bit is presented.
  output logic busy // High while sending.
);
  import cidm_pkg::*;

  cidm_state_t state; // Shifter state.
  cidm_state_t next_state; // Next shifter state.
  logic [31:0] sreg; // Shift register.
  logic [5:0] cnt; // Bits remaining.
  wire last_bit = (cnt == 6'h01); // Final bit is presented.

  // Next state selection.
  always_comb begin
    next_state = state;
    unique case (state)
      CIDM_IDLE: begin
        if (start && nbits != CIDM_CNT_RST) begin
          next_state = CIDM_SEND;
        end
      end
      CIDM_SEND: begin
        if (last_bit) begin
          next_state = CIDM_IDLE;
        end
      end
    endcase
  end

  // Shift register and counter; bit 31 leaves first.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state <= CIDM_IDLE;
      sreg <= 32'h0;
      cnt <= CIDM_CNT_RST;
    end else begin
      state <= next_state;
      if (state == CIDM_IDLE && start) begin
        sreg <= entry;
        cnt <= nbits;
      end else if (state == CIDM_SEND) begin
        sreg <= {sreg[30:0], 1'b1};
        cnt <= cnt - 6'h01;
      end
    end
  end

  assign bit_out = sreg[31];
  assign bit_valid = (state == CIDM_SEND);
  assign busy = (state == CIDM_SEND);

  // Sending a standard entry lasts exactly its 13 bits.
  AST_SHIFT_LEN: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state == CIDM_IDLE && start && nbits == CIDM_STD_BITS) |=>
    bit_valid [*8] ##1 bit_valid [*5] ##1 !bit_valid)
    else $error("Standard entry length wrong.");

  // The top bit of a loaded entry is the first one presented.
  AST_SHIFT_MSB: assert property (@(posedge SYS_CLK) disable iff (SRST)
    (state == CIDM_IDLE && start) |=> bit_out == $past(entry[31]))
    else $error("First bit is not the entry MSB.");
endmodule

// ### hw/cidm_top.sv
// Identifier field mapping for CAN message buffers, transmit and receive.
// Operation
// - Extended entry is 32 bits total.
// - Standard entry is 13 bits total.
// - Extended bytes 0,1 hold ID28..15, SRR, format.
// - Extended bytes 2,3 hold ID14..0 and RTR.
// - Identifier bit 28 is sent first; ID10 for a standard entry.
// - Smallest identifier value wins arbitration; here a standard identifier is compared as ID10..0 followed by 18 ones.
// - Receive stores SRR exactly as sampled.
// - Format flag zero standard, one extended.
// - Receive sets format flag as received.
// - Transmit format follows the written flag.
// - RTR zero data, one remote frame.
// - Receive sets RTR as received.
// - Extended layout has SRR and format one; SRR here is kept as received or as written, not forced to one.
// - Standard bytes 0,1 hold ID10..0, RTR, format.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module cidm_top (
  input wire logic SYS_CLK, // Bus clock, 100 MHz.
  input wire logic SRST, // Synchronous reset, active high.
  input wire logic [2:0] ADDR, // Register index.
  input wire logic [7:0] WDATA, // Register write data.
  input wire logic WR, // Write strobe.
  input wire logic RD, // Read strobe.
  output logic [7:0] RDATA, // Read data, one cycle after RD.
  input wire logic TX_START, // Request to send the transmit entry.
  output logic TX_BIT, // Serial identifier bit, first is MSB.
  output logic TX_BIT_VALID, // High while TX_BIT is meaningful.
  output logic TX_BUSY, // High while sending.
  input wire cidm_pkg::cidm_fields_t RX_FIELDS, // Received frame fields.
  input wire logic RX_STORE, // One-cycle strobe to store RX_FIELDS.
  input wire logic [28:0] ARB_OTHER, // Competing identifier.
  input wire logic ARB_OTHER_FMT, // Competing identifier format.
  output logic ARB_WIN // Own transmit identifier has priority.
);
  import cidm_pkg::*;

  logic [7:0] tx_b [4]; // Transmit identifier bytes.
  logic [7:0] rx_b [4]; // Receive identifier bytes.
  logic [7:0] rdata; // Read data register.
  cidm_req_t req; // Bundled register request.
  logic [31:0] tx_entry; // Packed transmit entry, left aligned.
  logic [5:0] tx_len; // Transmit entry length.
  logic [28:0] own_key; // Own identifier as arbitration key.
  logic [28:0] oth_key; // Competing identifier as arbitration key.

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Builds the four receive bytes from a received frame.
  function automatic logic [31:0] cidm_pack(input cidm_fields_t f);
    logic [31:0] p;
    p = 32'h0;
    if (f.fmt == CIDM_FMT_EXT) begin
      p[31:24] = f.ident[28:21];
      p[23:21] = f.ident[20:18];
      p[16 + CIDM_B1_SRR] = f.srr;
      p[16 + CIDM_B1_FMT] = CIDM_FMT_EXT;
      p[18:16] = f.ident[17:15];
      p[15:8] = f.ident[14:7];
      p[7:1] = f.ident[6:0];
      p[CIDM_B3_RTR_EXT] = f.rtr;
    end else begin
      p[31:24] = f.ident[10:3];
      p[23:21] = f.ident[2:0];
      p[16 + CIDM_B1_RTR_STD] = f.rtr;
      p[16 + CIDM_B1_FMT] = CIDM_FMT_STD;
    end
    return p;
  endfunction

  // Maps an identifier to an arbitration key; standard sits in the top.
  function automatic logic [28:0] cidm_key(input logic [28:0] id,
                                           input logic fmt);
    return (fmt == CIDM_FMT_EXT) ? id : {id[10:0], 18'h3ffff};
  endfunction

  wire [31:0] rx_packed = cidm_pack(RX_FIELDS); // Packed receive bytes.
  wire tx_ext = tx_b[1][CIDM_B1_FMT]; // Written format flag.

  // Transmit entry in sending order, MSB of identifier first.
  assign tx_entry = tx_ext ?
    {tx_b[0], tx_b[1][7:5], tx_b[1][CIDM_B1_SRR],
     tx_b[1][CIDM_B1_FMT], tx_b[1][2:0], tx_b[2], tx_b[3]} :
    {tx_b[0], tx_b[1][7:5], tx_b[1][CIDM_B1_RTR_STD],
     tx_b[1][CIDM_B1_FMT], 19'h0};
  assign tx_len = tx_ext ? CIDM_EXT_BITS : CIDM_STD_BITS;

  // Own identifier keys for the priority compare.
  wire [28:0] own_id = tx_ext ?
    {tx_b[0], tx_b[1][7:5], tx_b[1][2:0], tx_b[2], tx_b[3][7:1]} :
    {18'h0, tx_b[0], tx_b[1][7:5]};
  assign own_key = cidm_key(own_id, tx_ext);
  assign oth_key = cidm_key(ARB_OTHER, ARB_OTHER_FMT);

  // Smaller binary value has priority; ties go to this node.
  assign ARB_WIN = (own_key <= oth_key);

  // Register writes from software and stores from the receiver.
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      for (int i = 0; i < 4; i++) begin
        tx_b[i] <= CIDM_BYTE_RST;
        rx_b[i] <= CIDM_BYTE_RST;
      end
    end else begin
      if (req.wr && !req.addr[2]) begin
        tx_b[req.addr[1:0]] <= req.wdata;
      end
      if (RX_STORE) begin
        rx_b[0] <= rx_packed[31:24];
        rx_b[1] <= rx_packed[23:16];
        rx_b[2] <= rx_packed[15:8];
        rx_b[3] <= rx_packed[7:0];
      end
    end
  end

  // Read data register; valid only in the cycle after RD.
  wire [7:0] rd_sel = req.addr[2] ? rx_b[req.addr[1:0]] :
                      tx_b[req.addr[1:0]];
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rdata <= CIDM_BYTE_RST;
    end else begin
      rdata <= req.rd ? rd_sel : CIDM_BYTE_RST;
    end
  end
  assign RDATA = rdata;

  // Serialiser for the transmit entry.
  cidm_shift u_shift (
    .SYS_CLK(SYS_CLK),
    .SRST(SRST),
    .start(TX_START),
    .entry(tx_entry),
    .nbits(tx_len),
    .bit_out(TX_BIT),
    .bit_valid(TX_BIT_VALID),
    .busy(TX_BUSY)
  );

  // Checks of the mapping. Receive checks look one cycle after a store,
  // when the bytes have settled. Send checks count cycles from a taken
  // request: the first bit stands one cycle after it, and each later bit
  // one cycle further on, so bit k of the entry stands k cycles later.

  // Qualifiers shared by the checks below.
  wire tx_go = !TX_BUSY && TX_START; // Send request that is taken.
  wire tx_go_ext = tx_go && tx_ext; // Extended entry starts.
  wire tx_go_std = tx_go && !tx_ext; // Standard entry starts.
  wire rx_ext = RX_STORE && RX_FIELDS.fmt; // Extended frame stored.
  wire rx_std = RX_STORE && !RX_FIELDS.fmt; // Standard frame stored.

  // Received extended frame lands ID28..21 in byte 0.
  AST_RX_EXT_B0: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_ext |=> rx_b[0] == $past(RX_FIELDS.ident[28:21]))
    else $error("Extended byte 0 wrong.");

  // Byte 1 of an extended frame: ID20..18, SRR, format one, ID17..15.
  AST_RX_EXT_B1: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_ext |=>
    rx_b[1] == {$past(RX_FIELDS.ident[20:18]), $past(RX_FIELDS.srr), 1'b1,
                $past(RX_FIELDS.ident[17:15])})
    else $error("Extended byte 1 wrong.");

  // Byte 2 of an extended frame carries ID14..7.
  AST_RX_EXT_B2: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_ext |=> rx_b[2] == $past(RX_FIELDS.ident[14:7]))
    else $error("Extended byte 2 wrong.");

  // Byte 3 of an extended frame carries ID6..0 and the remote flag.
  AST_RX_EXT_B3: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_ext |=>
    rx_b[3] == {$past(RX_FIELDS.ident[6:0]), $past(RX_FIELDS.rtr)})
    else $error("Extended byte 3 wrong.");

  // The substitute bit is kept as sampled, even when it is dominant.
  AST_RX_SRR: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_ext |=>
    rx_b[1][CIDM_B1_SRR] == $past(RX_FIELDS.srr))
    else $error("Received SRR not kept.");

  // The format flag follows the received frame in both layouts.
  AST_RX_FMT: assert property (@(posedge SYS_CLK)
    disable iff (SRST)
    RX_STORE |=> rx_b[1][CIDM_B1_FMT] == $past(RX_FIELDS.fmt))
    else $error("Received format flag wrong.");

  // An extended receive entry always shows the format flag as one.
  AST_RX_EXT_IDE: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_ext |=> rx_b[1][CIDM_B1_FMT] == CIDM_FMT_EXT)
    else $error("Extended format flag not one.");

  // Standard frame lands ID10..3 in byte 0.
  AST_RX_STD_B0: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_std |=> rx_b[0] == $past(RX_FIELDS.ident[10:3]))
    else $error("Standard byte 0 wrong.");

  // Standard byte 1: ID2..0, remote flag, format zero.
  AST_RX_STD_RTR: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_std |=>
    rx_b[1][7:3] == {$past(RX_FIELDS.ident[2:0]), $past(RX_FIELDS.rtr), 1'b0})
    else $error("Standard byte 1 wrong.");

  // Unused bits of a standard receive entry read as zero.
  AST_RX_STD_REST: assert property (@(posedge SYS_CLK)
    disable iff (SRST) rx_std |=>
    rx_b[1][2:0] == 3'h0 && rx_b[2] == CIDM_BYTE_RST &&
    rx_b[3] == CIDM_BYTE_RST)
    else $error("Standard unused bits not zero.");

  // Software cannot overwrite a receive entry; only a store changes it.
  AST_RX_KEEP: assert property (@(posedge SYS_CLK)
    disable iff (SRST) WR && ADDR[2] && !RX_STORE |=>
    rx_b[0] == $past(rx_b[0]) && rx_b[1] == $past(rx_b[1]) &&
    rx_b[2] == $past(rx_b[2]) && rx_b[3] == $past(rx_b[3]))
    else $error("Receive entry changed by a write.");

  // A write to a transmit index lands in that byte.
  AST_TX_WRITE: assert property (@(posedge SYS_CLK)
    disable iff (SRST) WR && !ADDR[2] |=>
    tx_b[$past(ADDR[1:0])] == $past(WDATA))
    else $error("Transmit byte not written.");

  // The first extended bit sent is ID28.
  AST_TX_FIRST: assert property (@(posedge SYS_CLK)
    disable iff (SRST) tx_go_ext |=> TX_BIT == $past(tx_b[0][7]))
    else $error("First sent bit is not ID28.");

  // The first standard bit sent is ID10.
  AST_TX_STD_FIRST: assert property (@(posedge SYS_CLK)
    disable iff (SRST) tx_go_std |=> TX_BIT == $past(tx_b[0][7]))
    else $error("First sent bit is not ID10.");

  // An extended entry is sent as 32 bits, then the line goes quiet.
  AST_TX_EXT_LEN: assert property (@(posedge SYS_CLK)
    disable iff (SRST) tx_go_ext |=>
    TX_BIT_VALID [*8] ##1 TX_BIT_VALID [*8] ##1 TX_BIT_VALID [*8] ##1
    TX_BIT_VALID [*8] ##1 !TX_BIT_VALID)
    else $error("Extended send length wrong.");

  // A standard entry ends after 13 bits: the thirteenth bit is valid, the cycle after is not.
  AST_TX_STD_LAST: assert property (@(posedge SYS_CLK)
    disable iff (SRST)
    tx_go_std |=> ##12 TX_BIT_VALID ##1 !TX_BIT_VALID)
    else $error("Standard send length wrong.");

  // The thirteenth bit of a standard entry is the format flag, zero.
  AST_TX_STD_IDE: assert property (@(posedge SYS_CLK)
    disable iff (SRST) tx_go_std |=> ##12 TX_BIT == CIDM_FMT_STD)
    else $error("Standard format bit not zero.");

  // The thirteenth bit of an extended entry is the format flag, one.
  AST_TX_EXT_IDE: assert property (@(posedge SYS_CLK)
    disable iff (SRST) tx_go_ext |=> ##12 TX_BIT == CIDM_FMT_EXT)
    else $error("Extended format bit not one.");

  // The substitute bit goes out as software wrote it.
  AST_TX_EXT_SRR: assert property (@(posedge SYS_CLK)
    disable iff (SRST) tx_go_ext |=>
    ##11 TX_BIT == $past(tx_b[1][CIDM_B1_SRR], 12))
    else $error("Sent SRR differs from written.");

  // The last extended bit is the remote flag of byte 3.
  AST_TX_EXT_RTR: assert property (@(posedge SYS_CLK)
    disable iff (SRST) tx_go_ext |=>
    ##31 TX_BIT == $past(tx_b[3][CIDM_B3_RTR_EXT], 32))
    else $error("Sent extended RTR wrong.");

  // The twelfth standard bit is the remote flag of byte 1.
  AST_TX_STD_RTR: assert property (@(posedge SYS_CLK)
    disable iff (SRST) tx_go_std |=>
    ##11 TX_BIT == $past(tx_b[1][CIDM_B1_RTR_STD], 12))
    else $error("Sent standard RTR wrong.");

  // Between two extended identifiers the smaller one must win.
  AST_ARB: assert property (@(posedge SYS_CLK)
    disable iff (SRST)
    tx_ext && ARB_OTHER_FMT && own_id < ARB_OTHER |-> ARB_WIN)
    else $error("Lower identifier lost.");

  // Between two extended identifiers the larger one must lose.
  AST_ARB_LOSE: assert property (@(posedge SYS_CLK)
    disable iff (SRST)
    tx_ext && ARB_OTHER_FMT && own_id > ARB_OTHER |-> !ARB_WIN)
    else $error("Higher identifier won.");

  // Read data stand in the cycle after the strobe.
  AST_READ: assert property (@(posedge SYS_CLK)
    disable iff (SRST)
    RD && !WR && !RX_STORE |=> RDATA == $past(rd_sel))
    else $error("Read data wrong.");

  // Main scenarios that the bench should reach.
  COV_TX_EXT: cover property (@(posedge SYS_CLK) TX_START && tx_ext);
  COV_TX_STD: cover property (@(posedge SYS_CLK) TX_START && !tx_ext);
  COV_RX_EXT: cover property (@(posedge SYS_CLK) RX_STORE && RX_FIELDS.fmt);
  COV_RX_STD: cover property (@(posedge SYS_CLK) rx_std);
  COV_ARB_LOSE: cover property (@(posedge SYS_CLK) !ARB_WIN);
endmodule

// ### sim/cidm_partner.sv
// Far-side node model: captures sent bits, delivers received fields.
`timescale 1ns/1ps
module cidm_partner
  import cidm_pkg::*;
(
  input wire logic SYS_CLK, // Bus clock.
  input wire logic clr, // Clears the capture before a frame.
  input wire logic tx_bit, // Serial bit from the block.
  input wire logic tx_valid, // Qualifier of tx_bit.
  input wire logic go, // Deliver one received frame.
  input wire cidm_pkg::cidm_fields_t fld, // Fields of that frame.
  output logic [31:0] cap, // Captured bits, last one in bit 0.
  output logic [5:0] cnt, // Number of bits captured.
  output cidm_pkg::cidm_fields_t rx_fields, // Fields to the block.
  output logic rx_store // Store strobe to the block.
);
  // Shifts in each qualified bit, so the first bit ends up on top.
  always_ff @(posedge SYS_CLK) begin
    if (clr) begin
      cap <= 32'h0;
      cnt <= 6'h00;
    end else if (tx_valid) begin
      cap <= {cap[30:0], tx_bit};
      cnt <= cnt + 6'h01;
    end
  end
  // Fields are only meaningful with the strobe; otherwise inverted.
  always_ff @(posedge SYS_CLK) begin
    rx_store <= go;
    rx_fields <= go ? fld : ~fld;
  end
endmodule

// ### sim/cidm_top_bench.sv
// Bench for the identifier mapping block.
`timescale 1ns/1ps
module cidm_top_bench;
  import cidm_pkg::*;
  logic clk, srst, wr, rd, start, clr, go, ofmt, txb, txv, busy, win, rxs;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic [28:0] other, own;
  logic [31:0] cap;
  logic [5:0] cnt;
  cidm_fields_t fld, rxf;
  int err_count, compares;
  cidm_top u_cidm_top (.SYS_CLK(clk), .SRST(srst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .TX_START(start),
    .TX_BIT(txb), .TX_BIT_VALID(txv), .TX_BUSY(busy), .RX_FIELDS(rxf),
    .RX_STORE(rxs), .ARB_OTHER(other), .ARB_OTHER_FMT(ofmt),
    .ARB_WIN(win));
  cidm_partner u_cidm_partner (.SYS_CLK(clk), .clr(clr), .tx_bit(txb),
    .tx_valid(txv), .go(go), .fld(fld), .cap(cap), .cnt(cnt),
    .rx_fields(rxf), .rx_store(rxs));
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // One-cycle register write.
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read; the data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {24'h0, e}, {24'h0, rdata});
  endtask
  // Four bytes from index b, byte 0 in the top of v.
  task automatic put4(input logic [2:0] b, input logic [31:0] v);
    for (int k = 0; k < 4; k++) wr_reg(b + 3'(k), v[31-8*k -: 8]);
  endtask
  task automatic get4(input logic [2:0] b, input logic [31:0] v);
    for (int k = 0; k < 4; k++) rd_chk(b + 3'(k), v[31-8*k -: 8]);
  endtask
  // Sends the entry; a start while busy must not add bits.
  task automatic send(input logic [5:0] n, input logic [31:0] e);
    int k;
    @(posedge clk);
    start <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    clr <= 1'b0;
    repeat (4) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    chk("bit count", {26'h0, n}, {26'h0, cnt});
    chk("sent bits", e, cap);
  endtask
  // Competing extended identifier against the own one.
  task automatic arb(input logic [28:0] o, input logic e);
    @(posedge clk);
    other <= o;
    ofmt <= 1'b1;
    @(posedge clk);
    #1;
    chk("arb win", {31'h0, e}, {31'h0, win});
  endtask
  // The far side hands over one received frame.
  task automatic deliver(input logic [28:0] i, input logic s, f, r);
    @(posedge clk);
    fld <= '{ident: i, srr: s, fmt: f, rtr: r};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic final_report;
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Clock, 10 ns period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hang ends the run as a failure.
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    final_report();
  end
  // Main sequence.
  initial begin
    {srst, wr, rd, start, clr, go, ofmt} = 7'h40;
    {addr, wdata, other} = '0;
    fld = '0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    get4(3'h0, 32'h0);
    get4(3'h4, 32'h0);
    put4(3'h0, 32'ha57a3c97);
    get4(3'h0, 32'ha57a3c97);
    send(6'h20, 32'ha57a3c97);
    own = {8'ha5, 6'h1a, 8'h3c, 7'h4b};
    arb(own + 29'h1, 1'b1);
    arb(own - 29'h1, 1'b0);
    arb(own, 1'b1);
    wr_reg(3'h0, 8'h5c);
    wr_reg(3'h1, 8'ha7);
    send(6'h0d, 32'h00000b94);
    wr_reg(3'h4, 8'hff);
    rd_chk(3'h4, 8'h00);
    deliver({8'h3e, 6'h31, 8'hc4, 7'h55}, 1'b0, 1'b1, 1'b0);
    get4(3'h4, 32'h3ec9c4aa);
    deliver(29'h5a3, 1'b0, 1'b0, 1'b1);
    get4(3'h4, 32'hb4700000);
    final_report();
  end
endmodule
